//--- dfj_consts.vh
// constants for the fire judgement and learning block
`ifndef DFJ_CONSTS_VH
`define DFJ_CONSTS_VH
// ==========================================
// register byte offsets
`define DFJ_OFF_CTRL      8'h00
`define DFJ_OFF_STATUS    8'h04
`define DFJ_OFF_MARKS1    8'h08
`define DFJ_OFF_MARKS2    8'h0c
`define DFJ_OFF_MARKS3    8'h10
`define DFJ_OFF_ALMCLR    8'h14
// ==========================================
// field positions, and the control reset value
`define DFJ_CTRL_EN       0
`define DFJ_CTRL_MULTI    1
`define DFJ_CTRL_RST      2'h3
`define DFJ_ST_CNT_LO     0
`define DFJ_ST_COND_LO    8
`define DFJ_ST_ALARM      16
`define DFJ_ST_JUDGED     17
`define DFJ_ST_LVL_LO     18
`define DFJ_ST_DLY        21
`define DFJ_ALMCLR_BIT    0
// ==========================================
// thresholds, all values in tenths of their unit
`define DFJ_S_SMOKE_ONLY  16'h0028
`define DFJ_S_NORMAL      16'h0032
`define DFJ_S_CLEAN       16'h0025
`define DFJ_T_FIRE        16'h023a
`define DFJ_R_FIRE        16'h00b4
`define DFJ_C_NORMAL      16'h0078
`define DFJ_C_CLEAN       16'h0064
`define DFJ_C_COOK        16'h008c
`define DFJ_L2_RISE       16'h0078
`define DFJ_L3_INDEX      16'h0064
`define DFJ_L3_SMOKE      16'h0019
`define DFJ_L3_RISE       16'h001e
// ==========================================
// counter figures
`define DFJ_CNT_FIRE      8'h09
`define DFJ_CNT_MAX       8'hff
`define DFJ_ADD_SMOKE     8'h01
`define DFJ_ADD_TEMP      8'h03
`define DFJ_SUB           8'h02
`define DFJ_MARKS_ADOPT   5'h03
`define DFJ_SLOTS         20
`define DFJ_SLOT_LAST     5'h13
// ==========================================
// timing
`define DFJ_CLK_KHZ       20000
`define DFJ_TICK_MS       1000
`define DFJ_SLOT_HOURS    36
`define DFJ_SEC_PER_HOUR  3600
`define DFJ_DLY_DEFAULT   8'h09
`endif

//--- dfj_fire_judge.v
// fire judgement counter, learning history and apb registers
//
// Functional notes
// - up-down counter starts zero, floors at zero
// - smoke or index hit adds 1, else subtract 2
// - temperature or rise hit adds 3, else subtract 2
// - counter nine judges fire; smoke-only alarms at once
// - multi variant alarms after condition-dependent delay
// - smoke-only uses 4 %/m, Normal only
// - normal and steam thresholds 5, 57, 18, 12
// - clean lowers, heating drops rise, cooking raises
// - normal after reset and by default
// - level 1: smoke at half smoke threshold
// - level 2: rise 12 or more
// - level 3: index 10 with smoke, rise minimums
// - twenty 36h slots, marked when level exceeded
// - three level-1 marks adopt steam condition
// - slot 20 wraps to 1, marks overwritten
// - fewer than three marks leaves steam condition
// - same mechanism for heating and cooking
// - clean only with no marks anywhere
// - any new mark leaves clean at once
// - learning runs only in multi variant
`include "dfj_consts.vh"

module dfj_fire_judge #(
	parameter [31:0] TICK_CYCLES = `DFJ_TICK_MS * `DFJ_CLK_KHZ,
	parameter [31:0] SLOT_TICKS  = `DFJ_SLOT_HOURS * `DFJ_SEC_PER_HOUR,
	parameter [7:0]  DLY_NORMAL  = `DFJ_DLY_DEFAULT,
	parameter [7:0]  DLY_STEAM   = `DFJ_DLY_DEFAULT,
	parameter [7:0]  DLY_HEAT    = `DFJ_DLY_DEFAULT,
	parameter [7:0]  DLY_COOK    = `DFJ_DLY_DEFAULT,
	parameter [7:0]  DLY_CLEAN   = `DFJ_DLY_DEFAULT,
	// cook first: every level-3 hit is a level-1 hit as well
	parameter [5:0]  PRIO        = 6'h39
) (
	input  wire        pclk,           // bus and logic clock
	input  wire        presetn,        // async reset, active low
	input  wire        psel,           // apb select
	input  wire        penable,        // apb access phase
	input  wire        pwrite,         // apb write
	input  wire [7:0]  paddr,          // apb byte address
	input  wire [31:0] pwdata,         // apb write data
	output reg  [31:0] prdata,         // apb read data
	output wire        pready,         // apb ready
	output reg         pslverr,        // apb error on unmapped address
	input  wire [15:0] smoke_value,    // obscuration, tenths of %/m
	input  wire [15:0] temp_value,     // temperature, tenths of degree
	input  wire [15:0] temp_rise,      // rise per 168 s, tenths
	input  wire [15:0] combined_index, // smoke plus rise index, tenths
	output reg         fire_alarm,     // latched fire alarm
	output reg  [4:0]  condition       // one-hot active condition
);

	// ==========================================
	// conditions, one-hot
	localparam [4:0] C_NORMAL = 5'h01;
	localparam [4:0] C_STEAM  = 5'h02;
	localparam [4:0] C_HEAT   = 5'h04;
	localparam [4:0] C_COOK   = 5'h08;
	localparam [4:0] C_CLEAN  = 5'h10;

	function [4:0] pop20;
		input [19:0] v;
		integer i;
		begin
			pop20 = 5'h00;
			for (i = 0; i < `DFJ_SLOTS; i = i + 1)
				pop20 = pop20 + {4'h0, v[i]};
		end
	endfunction

	// pick among qualifying steam(1), heat(2), cook(3) in PRIO order
	function [4:0] pick;
		input [2:0] q;
		input [5:0] pr;
		integer k;
		reg [1:0] c;
		reg       done;
		begin
			pick = C_NORMAL;
			done = 1'b0;
			for (k = 2; k >= 0; k = k - 1) begin
				c = pr[2*k +: 2];
				if (!done && c != 2'h0 && q[c - 2'h1]) begin
					done = 1'b1;
					pick = {1'b0, 4'h1 << c} ;
				end
			end
		end
	endfunction

	// ==========================================
	// one-second tick
	reg  [31:0] div_reg;
	reg         tick;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_reg <= 32'h0;
			tick    <= 1'b0;
		end else if (div_reg >= TICK_CYCLES - 32'h1) begin
			div_reg <= 32'h0;
			tick    <= 1'b1;
		end else begin
			div_reg <= div_reg + 32'h1;
			tick    <= 1'b0;
		end
	end

	// ==========================================
	// apb registers
	reg  [1:0]  ctrl_reg;
	wire        en    = ctrl_reg[`DFJ_CTRL_EN];
	wire        multi = ctrl_reg[`DFJ_CTRL_MULTI];
	wire        wr_en = psel & penable & pwrite;
	wire        setup = psel & ~penable;
	wire        alm_clr = wr_en & (paddr == `DFJ_OFF_ALMCLR) & pwdata[`DFJ_ALMCLR_BIT];
	reg  [7:0]  cnt_reg;
	reg  [7:0]  dly_reg;
	reg         dly_run;
	wire [2:0]  cur_seen;
	wire [3*`DFJ_SLOTS-1:0] marks_all;
	reg  [4:0]  slot_idx;
	reg  [31:0] slot_cnt;
	wire [2:0]  lvl;
	wire        judged = cnt_reg >= `DFJ_CNT_FIRE;
	assign pready = 1'b1;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= `DFJ_CTRL_RST;
			prdata   <= 32'h0;
			pslverr  <= 1'b0;
		end else begin
			if (wr_en && paddr == `DFJ_OFF_CTRL) begin
				ctrl_reg <= pwdata[1:0];
			end
			if (setup) begin
				pslverr <= 1'b0;
				prdata  <= 32'h0;
				case (paddr)
				`DFJ_OFF_CTRL:   prdata <= {30'h0, ctrl_reg};
				`DFJ_OFF_STATUS: prdata <= {10'h0, dly_run, lvl, judged, fire_alarm,
							3'h0, condition, cnt_reg};
				`DFJ_OFF_MARKS1: prdata <= {12'h0, marks_all[0 +: `DFJ_SLOTS]};
				`DFJ_OFF_MARKS2: prdata <= {12'h0, marks_all[`DFJ_SLOTS +: `DFJ_SLOTS]};
				`DFJ_OFF_MARKS3: prdata <= {12'h0, marks_all[2 * `DFJ_SLOTS +: `DFJ_SLOTS]};
				`DFJ_OFF_ALMCLR: prdata <= 32'h0;
				default:         pslverr <= 1'b1;
				endcase
			end
		end
	end

	// ==========================================
	// thresholds for the active condition
	reg  [15:0] thr_s;
	reg  [15:0] thr_c;
	reg         rise_use;
	always @* begin
		thr_s    = `DFJ_S_NORMAL;
		thr_c    = `DFJ_C_NORMAL;
		rise_use = 1'b1;
		if (!multi) begin
			thr_s = `DFJ_S_SMOKE_ONLY;
		end else if (condition == C_CLEAN) begin
			thr_s = `DFJ_S_CLEAN;
			thr_c = `DFJ_C_CLEAN;
		end else if (condition == C_HEAT) begin
			rise_use = 1'b0;
		end else if (condition == C_COOK) begin
			thr_c = `DFJ_C_COOK;
		end
	end

	wire smk_hit = (smoke_value >= thr_s) | (multi & (combined_index >= thr_c));
	wire tmp_hit = multi & ((temp_value >= `DFJ_T_FIRE) |
			(rise_use & (temp_rise >= `DFJ_R_FIRE)));

	// ==========================================
	// pulse up-down counter, evaluated on each tick
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= 8'h00;
		end else if (!en) begin
			cnt_reg <= 8'h00;
		end else if (tick) begin
			if (tmp_hit) begin
				cnt_reg <= (cnt_reg > `DFJ_CNT_MAX - `DFJ_ADD_TEMP) ?
					`DFJ_CNT_MAX : cnt_reg + `DFJ_ADD_TEMP;
			end else if (smk_hit) begin
				cnt_reg <= (cnt_reg == `DFJ_CNT_MAX) ?
					`DFJ_CNT_MAX : cnt_reg + `DFJ_ADD_SMOKE;
			end else begin
				cnt_reg <= (cnt_reg < `DFJ_SUB) ? 8'h00 : cnt_reg - `DFJ_SUB;
			end
		end
	end

	// ==========================================
	// fire judgement and alarm delay
	reg [7:0] dly_sel;
	always @* begin
		case (condition)
		C_STEAM: dly_sel = DLY_STEAM;
		C_HEAT:  dly_sel = DLY_HEAT;
		C_COOK:  dly_sel = DLY_COOK;
		C_CLEAN: dly_sel = DLY_CLEAN;
		default: dly_sel = DLY_NORMAL;
		endcase
	end

	// smoke-only alarms as soon as the counter stands at nine
	wire fire_set = en & judged & (~multi |
			(tick & dly_run & (dly_reg == 8'h00)));
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fire_alarm <= 1'b0;
			dly_run    <= 1'b0;
			dly_reg    <= 8'h00;
		end else begin
			// a new fire wins over a clear in the same cycle
			if (fire_set) begin
				fire_alarm <= 1'b1;
			end else if (alm_clr) begin
				fire_alarm <= 1'b0;
			end
			if (!en || !judged || !multi) begin
				dly_run <= 1'b0;
			end else if (tick) begin
				if (!dly_run) begin
					dly_run <= 1'b1;
					dly_reg <= dly_sel;
				end else if (dly_reg != 8'h00) begin
					dly_reg <= dly_reg - 8'h01;
				end
			end
		end
	end

	// ==========================================
	// learning levels
	wire learn = en & multi;
	assign lvl[0] = smoke_value >= {1'b0, thr_s[15:1]};
	assign lvl[1] = temp_rise >= `DFJ_L2_RISE;
	assign lvl[2] = (combined_index >= `DFJ_L3_INDEX) &
			(smoke_value >= `DFJ_L3_SMOKE) & (temp_rise >= `DFJ_L3_RISE);
	wire slot_end = tick & (slot_cnt >= SLOT_TICKS - 32'h1);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slot_cnt <= 32'h0;
			slot_idx <= 5'h00;
		end else if (!learn) begin
			slot_cnt <= 32'h0;
			slot_idx <= 5'h00;
		end else if (slot_end) begin
			slot_cnt <= 32'h0;
			slot_idx <= (slot_idx == `DFJ_SLOT_LAST) ? 5'h00 : slot_idx + 5'h01;
		end else if (tick) begin
			slot_cnt <= slot_cnt + 32'h1;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_lvl
			reg        seen_reg;
			reg [19:0] mark_reg;
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					seen_reg <= 1'b0;
					mark_reg <= 20'h0;
				end else if (!learn) begin
					seen_reg <= 1'b0;
					mark_reg <= 20'h0;
				end else if (slot_end) begin
					mark_reg[slot_idx] <= seen_reg | lvl[g];
					seen_reg <= 1'b0;
				end else if (tick && lvl[g]) begin
					seen_reg <= 1'b1;
				end
			end
			assign cur_seen[g] = seen_reg;
			assign marks_all[`DFJ_SLOTS * g +: `DFJ_SLOTS] = mark_reg;
		end
	endgenerate

	// ==========================================
	// condition selection
	wire [2:0] qual;
	assign qual[0] = pop20(marks_all[0 +: `DFJ_SLOTS]) >= `DFJ_MARKS_ADOPT;
	assign qual[1] = pop20(marks_all[`DFJ_SLOTS +: `DFJ_SLOTS]) >= `DFJ_MARKS_ADOPT;
	assign qual[2] = pop20(marks_all[2 * `DFJ_SLOTS +: `DFJ_SLOTS]) >= `DFJ_MARKS_ADOPT;
	wire any_mark = (|marks_all) | (|cur_seen) | (tick & (|lvl));

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			condition <= C_NORMAL;
		end else if (!learn) begin
			condition <= C_NORMAL;
		end else begin
			case (condition)
			C_CLEAN: begin
				if (any_mark)
					condition <= C_NORMAL;
			end
			C_NORMAL, C_STEAM, C_HEAT, C_COOK: begin
				if (|qual)
					condition <= pick(qual, PRIO);
				else if (!any_mark && slot_end && slot_idx == `DFJ_SLOT_LAST)
					condition <= C_CLEAN;
				else
					condition <= C_NORMAL;
			end
			default: condition <= C_NORMAL;
			endcase
		end
	end

endmodule // dfj_fire_judge

//--- dfj_sensor_model.sv
// sensor front end model: one reading set per clock
module dfj_sensor_model (
	input  wire         pclk,  // clock
	input  wire  [63:0] scene, // smoke, temp, rise, index asked for
	output logic [63:0] vals   // readings seen by the block
);
	timeunit 1ns;
	timeprecision 1ns;
	always @(posedge pclk) vals <= scene;
endmodule // dfj_sensor_model

//--- dfj_fire_judge_chk.sv
// port checks for the fire judgement block
module dfj_fire_judge_chk #(
	parameter [31:0] TICK_CYCLES = 32'h0000000a // cycles per tick
) (
	input wire        pclk,           // clock
	input wire        presetn,        // reset
	input wire        psel,           // select
	input wire        penable,        // access
	input wire        pwrite,         // write
	input wire [7:0]  paddr,          // address
	input wire [31:0] pwdata,         // wdata
	input wire [31:0] prdata,         // rdata
	input wire        pready,         // ready
	input wire        pslverr,        // error
	input wire [15:0] smoke_value,    // smoke
	input wire [15:0] temp_value,     // temp
	input wire [15:0] temp_rise,      // rise
	input wire [15:0] combined_index, // index
	input wire        fire_alarm,     // alarm
	input wire [4:0]  condition       // condition
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int CW = TICK_CYCLES + 3;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_bad;
		psel && !penable && paddr > 8'h14;
	endsequence
	sequence s_good;
		psel && !penable && paddr <= 8'h14 && paddr[1:0] == 2'h0;
	endsequence
	a_ready_high: assert property (pready)
		else $error("pready low");
	a_err_unmapped: assert property (s_bad ##1 psel && penable |-> pslverr)
		else $error("no error on unmapped");
	a_err_mapped: assert property (s_good ##1 psel && penable |-> !pslverr)
		else $error("error on mapped");
	a_err_rdzero: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
		else $error("refused read not zero");
	a_reset_normal: assert property ($rose(presetn) |-> condition == 5'h01)
		else $error("not normal after reset");
	a_cond_onehot: assert property ($onehot(condition))
		else $error("condition not one-hot");
	a_alarm_latch: assert property ($fell(fire_alarm) |->
		$past(psel && penable && pwrite && paddr == 8'h14 && pwdata[0]))
		else $error("alarm fell without clear");
	a_clean_exit: assert property (condition[4] && smoke_value >= 16'h0012
		|-> ##[0:CW] (!condition[4] || smoke_value < 16'h0012))
		else $error("clean kept with level hit");
endmodule // dfj_fire_judge_chk
bind dfj_fire_judge dfj_fire_judge_chk #(.TICK_CYCLES(TICK_CYCLES)) i_dfj_fire_judge_chk (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
	.pslverr, .smoke_value, .temp_value, .temp_rise, .combined_index, .fire_alarm,
	.condition);

//--- tb_top.sv
// self-checking bench for the fire judgement block
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TK = 10;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, fire_alarm;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [4:0]  condition;
	logic [63:0] scene, vals;
	logic [15:0] thr [4] = '{16'h0031, 16'h0239, 16'h00b3, 16'h0077};
	int          fail_count, n_compared, cyc, t0, pv;
	dfj_sensor_model i_dfj_sensor_model (.pclk, .scene, .vals);
	dfj_fire_judge #(.TICK_CYCLES(32'h0000000a), .SLOT_TICKS(32'h00000003),
		.DLY_NORMAL(8'h02)) i_dfj_fire_judge (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.smoke_value(vals[63:48]), .temp_value(vals[47:32]), .temp_rise(vals[31:16]),
		.combined_index(vals[15:0]), .fire_alarm, .condition);
	initial begin
		pclk = 1'h0;
		forever #25 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
		n_compared++;
		if (s !== e) begin
			fail_count++;
			$display("[ERR] %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic rdr(logic [7:0] a);
		wr(1'h0, a, 32'h0);
	endtask
	task automatic poll(logic [31:0] v);
		int n = 0;
		do begin
			rdr(8'h04);
			n++;
		end while ((rd & 32'h1f00) !== v && n < 900);
		chk("condition", v, rd & 32'h1f00);
	endtask
	task automatic judged();
		int n = 0;
		do begin
			rdr(8'h04);
			n++;
		end while (rd[17] !== 1'h1 && n < 300);
		chk("judged count", 32'h9, rd[7:0]);
	endtask
	task automatic wait_alarm();
		t0 = 0;
		while (fire_alarm !== 1'h1 && t0 < 200) begin
			@(posedge pclk);
			t0++;
		end
	endtask
	task automatic relearn();
		wr(1'h1, 8'h00, 32'h2);
		wr(1'h1, 8'h00, 32'h3);
	endtask
	task automatic marks(logic [7:0] a, int n);
		rdr(a);
		chk("marks", n, $countones(rd[19:0]));
	endtask
	initial begin
		{psel, penable, pwrite, paddr, pwdata, scene, fail_count, n_compared} = '0;
		presetn = 1'h0;
		repeat (5) @(posedge pclk);
		presetn <= 1'h1;
		rdr(8'h00);
		chk("ctrl", 32'h3, rd);
		rdr(8'h04);
		chk("status", 32'h100, rd);
		rdr(8'h18);
		chk("unmapped", 32'h1, er);
		$display("reset done");
		wr(1'h1, 8'h00, 32'h1);
		scene <= {16'h0027, 48'h0};
		repeat (4 * TK) @(posedge pclk);
		rdr(8'h04);
		chk("below", 32'h0, rd[7:0]);
		scene <= {16'h0028, 48'h0};
		judged();
		chk("at once", 32'h1, fire_alarm);
		wait_alarm();
		chk("alarm time", 32'h1, t0 == 0);
		scene <= 64'h0;
		wr(1'h1, 8'h00, 32'h0);
		chk("latched", 32'h1, fire_alarm);
		wr(1'h1, 8'h14, 32'h1);
		@(posedge pclk);
		chk("cleared", 32'h0, fire_alarm);
		$display("smoke-only done");
		wr(1'h1, 8'h00, 32'h3);
		scene <= {16'h0, 16'h023a, 32'h0};
		judged();
		wait_alarm();
		chk("delay", 32'h1, t0 > 3 * TK && t0 <= 4 * TK + 2);
		scene <= 64'h0;
		pv = 21;
		repeat (45) begin
			rdr(8'h04);
			if (rd[7:0] != pv) begin
				chk("down", pv > 2 ? pv - 2 : 0, rd[7:0]);
				pv = rd[7:0];
			end
		end
		chk("floor", 32'h0, pv);
		$display("delay done");
		for (int i = 0; i < 8; i++) begin
			wr(1'h1, 8'h00, 32'h2);
			scene <= 64'(thr[i / 2] + i % 2) << (48 - 16 * (i / 2));
			wr(1'h1, 8'h00, 32'h3);
			repeat (35) @(posedge pclk);
			rdr(8'h04);
			chk("threshold", i % 2, rd[7:0] != 0);
		end
		$display("thresholds done");
		relearn();
		scene <= {16'h0019, 48'h0};
		poll(32'h0200);
		marks(8'h08, 3);
		scene <= 64'h0;
		poll(32'h0100);
		marks(8'h08, 2);
		relearn();
		scene <= {32'h0, 16'h0078, 16'h0};
		poll(32'h0400);
		marks(8'h0c, 3);
		scene <= {32'h0, 16'h00b4, 16'h0};
		repeat (4 * TK) @(posedge pclk);
		rdr(8'h04);
		chk("rise ignored", 32'h0, rd[7:0]);
		relearn();
		scene <= {16'h0019, 16'h0, 16'h001e, 16'h0064};
		poll(32'h0800);
		marks(8'h10, 3);
		scene <= {16'h0019, 16'h0, 16'h001e, 16'h0082};
		repeat (4 * TK) @(posedge pclk);
		rdr(8'h04);
		chk("index raised", 32'h0, rd[7:0]);
		relearn();
		scene <= 64'h0;
		poll(32'h1000);
		scene <= {48'h0, 16'h0064};
		repeat (4 * TK) @(posedge pclk);
		rdr(8'h04);
		chk("clean index", 32'h1, rd[7:0] != 0);
		scene <= {16'h0012, 48'h0};
		poll(32'h0100);
		$display("learning done");
		stop_test();
	end
endmodule // tb_top
